// ---- common/lmzc_pkg.sv ----
// Constants for the mode register write, ZQ and clock change block
package lmzc_pkg;
    // ************************************************
    // Clock periods in ns
    // ************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_CK_NS    = 12;
    // ************************************************
    // Timing in ns and derived core cycles
    // ************************************************
    localparam int T_MRW_NS      = 250;
    localparam int T_ZQRESET_NS  = 500;
    localparam int T_ZQCS_NS     = 1000;
    localparam int T_ZQCL_NS     = 4000;
    localparam int T_ZQINIT_NS   = 10000;
    localparam int T_INIT4_NS    = 10000;
    localparam int T_XP_NS       = 100;
    localparam int T_STOP_NS     = 400;
    localparam int MRW_CYC       = (T_MRW_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int ZQRESET_CYC   = (T_ZQRESET_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int ZQCS_CYC      = (T_ZQCS_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int ZQCL_CYC      = (T_ZQCL_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int ZQINIT_CYC    = (T_ZQINIT_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int INIT4_CYC     = (T_INIT4_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int RDY_CYC       = (2 * LINK_CK_NS + T_XP_NS
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_CYC      = T_STOP_NS / CLK_PERIOD_NS;
    // ************************************************
    // Field positions and codes
    // ************************************************
    localparam int CA_W          = 10;
    localparam int MA_LO_POS     = 4;
    localparam int OP_LO_POS     = 2;
    localparam int HB_BIT        = 3;
    localparam logic [1:0] LINK_RDY_EDGES = 2'h2;
    localparam logic [7:0] RESET_MA_DEF   = 8'h3f;
    localparam logic [7:0] ZQ_MA_DEF      = 8'h0a;
    localparam logic [7:0] ZQ_INIT_CODE   = 8'h01;
    localparam logic [7:0] ZQ_LONG_CODE   = 8'h02;
    localparam logic [7:0] ZQ_SHORT_CODE  = 8'h03;
    localparam logic [7:0] ZQ_RESET_CODE  = 8'h04;
    localparam logic [7:0] MR_RESET_VAL   = 8'h00;
    localparam logic [1:0] ZQ_KIND_NONE   = 2'h0;
    localparam logic [1:0] ZQ_KIND_INIT   = 2'h1;
    localparam logic [1:0] ZQ_KIND_LONG   = 2'h2;
    localparam logic [1:0] ZQ_KIND_SHORT  = 2'h3;

    typedef enum logic [1:0] {
        LMZC_IDLE = 2'b00,
        LMZC_MRW  = 2'b01,
        LMZC_INIT = 2'b10,
        LMZC_ZQ   = 2'b11
    } lmzc_state_t;
endpackage : lmzc_pkg

// ---- rtl/lmzc_core.sv ----
// Mode register write decode, reset, ZQ calibration and clock change ready
//
// Notes on behaviour
// - Write decoded on rising edge with select low and CA0..CA3 low.
// - Address from CA1..CA0 falling plus CA9..CA4 rising, eight bits.
// - Data from CA9..CA2 sampled on the falling edge.
// - Writes to read-only registers leave the register unchanged but still run the write busy period.
// - Write and reset accepted only from idle; refused with banks active.
// - Reset write enters auto-initialization and restores register defaults.
// - Array contents flagged undefined after a reset write completes.
// - Calibration register write starts one of four ZQ commands.
// - ZQ reset returns impedance to its default setting.
// - Calibration pin strapped to supply: ZQ commands ignored.
// - Ready after two valid clocks plus power-down exit time.
`timescale 1ns/1ps
module lmzc_core #(
    parameter int         NUM_MR     = 16,
    parameter logic [15:0] RO_MASK   = 16'h0003,
    parameter logic [127:0] MR_DEF   = 128'h0,
    parameter logic [7:0] RESET_MA   = lmzc_pkg::RESET_MA_DEF,
    parameter logic [7:0] ZQ_MA      = lmzc_pkg::ZQ_MA_DEF,
    parameter int         INIT4_CYC  = lmzc_pkg::INIT4_CYC,
    parameter int         ZQINIT_CYC = lmzc_pkg::ZQINIT_CYC,
    parameter int         ZQCL_CYC   = lmzc_pkg::ZQCL_CYC
) (
    // Core clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Link pins from the controller
    input  wire logic                     ck_t,
    input  wire logic                     cke,
    input  wire logic                     cs_n,
    input  wire logic [lmzc_pkg::CA_W-1:0] ca,
    // Calibration strap pin
    input  wire logic                     zq_tied_high,
    // Device side status and readback
    input  wire logic                     banks_idle,
    input  wire logic                     array_clr,
    input  wire logic [3:0]               mr_rd_idx,
    output logic [7:0]                    mr_rd_data,
    output logic                          mrw_busy,
    output logic                          init_busy,
    output logic                          zq_busy,
    output logic [1:0]                    zq_kind,
    output logic                          zq_default,
    output logic                          array_undef,
    output logic                          mrw_refused,
    output logic                          dev_ready
);
    // ************************************************
    // Link domain capture
    // ************************************************
    logic [lmzc_pkg::CA_W-1:0] ca_fall_reg;
    logic                      cke_prev_reg;
    logic                      pend_reg;
    logic [5:0]                ma_hi_reg;
    logic [7:0]                l_ma_reg;
    logic [7:0]                l_op_reg;
    logic                      l_tog_reg;
    logic [1:0]                l_rdy_cnt_reg;
    logic [lmzc_pkg::HB_BIT:0] l_hb_reg;
    logic                      mrw_cmd;

    assign mrw_cmd = cke && cke_prev_reg && !cs_n
                     && (ca[3:0] == 4'h0);

    always_ff @(negedge ck_t or negedge rst_n) begin
        if (!rst_n) begin
            ca_fall_reg <= '0;
        end else begin
            ca_fall_reg <= ca;
        end
    end

    always_ff @(posedge ck_t or negedge rst_n) begin
        if (!rst_n) begin
            cke_prev_reg <= 1'b0;
            pend_reg     <= 1'b0;
            ma_hi_reg    <= 6'h00;
            l_ma_reg     <= 8'h00;
            l_op_reg     <= 8'h00;
            l_tog_reg    <= 1'b0;
        end else begin
            cke_prev_reg <= cke;
            pend_reg     <= mrw_cmd;
            if (mrw_cmd) begin
                ma_hi_reg <= ca[lmzc_pkg::MA_LO_POS +: 6];
            end
            if (pend_reg) begin
                l_ma_reg  <= {ca_fall_reg[1:0], ma_hi_reg};
                l_op_reg  <= ca_fall_reg[lmzc_pkg::OP_LO_POS +: 8];
                l_tog_reg <= ~l_tog_reg;
            end
        end
    end

    // Valid clock edges seen with CKE high, and a slow heartbeat
    always_ff @(posedge ck_t or negedge rst_n) begin
        if (!rst_n) begin
            l_rdy_cnt_reg <= 2'h0;
            l_hb_reg      <= '0;
        end else begin
            l_hb_reg <= l_hb_reg + (lmzc_pkg::HB_BIT + 1)'(1);
            if (!cke) begin
                l_rdy_cnt_reg <= 2'h0;
            end else if (l_rdy_cnt_reg != lmzc_pkg::LINK_RDY_EDGES) begin
                l_rdy_cnt_reg <= l_rdy_cnt_reg + 2'h1;
            end
        end
    end

    // ************************************************
    // Crossing into the core domain
    // ************************************************
    logic [2:0] tog_sync_reg;
    logic [2:0] hb_sync_reg;
    logic [1:0] rdy_sync_reg;
    logic [1:0] zq_sync_reg;
    logic       wr_evt;
    logic       hb_evt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_sync_reg <= 3'h0;
            hb_sync_reg  <= 3'h0;
            rdy_sync_reg <= 2'h0;
            zq_sync_reg  <= 2'h0;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], l_tog_reg};
            hb_sync_reg  <= {hb_sync_reg[1:0], l_hb_reg[lmzc_pkg::HB_BIT]};
            rdy_sync_reg <= {rdy_sync_reg[0],
                             l_rdy_cnt_reg == lmzc_pkg::LINK_RDY_EDGES};
            zq_sync_reg  <= {zq_sync_reg[0], zq_tied_high};
        end
    end

    assign wr_evt = tog_sync_reg[2] ^ tog_sync_reg[1];
    assign hb_evt = hb_sync_reg[2] ^ hb_sync_reg[1];

    // ************************************************
    // Command sequencing
    // ************************************************
    lmzc_pkg::lmzc_state_t state_reg;
    logic [19:0]           timer_reg;
    logic [7:0]            mr_reg [NUM_MR];
    logic                  ro_hit;
    logic                  in_range;
    logic                  is_reset;
    logic                  is_zq;
    logic                  init_done;

    assign in_range  = (l_ma_reg < NUM_MR[7:0]);
    assign ro_hit    = !in_range || RO_MASK[l_ma_reg[3:0]];
    assign is_reset  = (l_ma_reg == RESET_MA);
    assign is_zq     = (l_ma_reg == ZQ_MA);
    assign init_done = (state_reg == lmzc_pkg::LMZC_INIT)
                       && (timer_reg == 20'h0);

    function automatic logic [19:0] zq_len(input logic [7:0] code);
        if (code == lmzc_pkg::ZQ_INIT_CODE) begin
            zq_len = 20'(ZQINIT_CYC);
        end else if (code == lmzc_pkg::ZQ_LONG_CODE) begin
            zq_len = 20'(ZQCL_CYC);
        end else if (code == lmzc_pkg::ZQ_SHORT_CODE) begin
            zq_len = 20'(lmzc_pkg::ZQCS_CYC);
        end else begin
            zq_len = 20'(lmzc_pkg::ZQRESET_CYC);
        end
    endfunction : zq_len

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= lmzc_pkg::LMZC_IDLE;
            timer_reg   <= 20'h0;
            zq_kind     <= lmzc_pkg::ZQ_KIND_NONE;
            mrw_refused <= 1'b0;
        end else begin
            mrw_refused <= 1'b0;
            if (timer_reg != 20'h0) begin
                timer_reg <= timer_reg - 20'h1;
            end
            case (state_reg)
                lmzc_pkg::LMZC_IDLE: begin
                    if (wr_evt && !banks_idle) begin
                        mrw_refused <= 1'b1;
                    end else if (wr_evt && is_reset) begin
                        state_reg <= lmzc_pkg::LMZC_INIT;
                        timer_reg <= 20'(INIT4_CYC);
                    end else if (wr_evt && is_zq && !zq_sync_reg[1]) begin
                        state_reg <= lmzc_pkg::LMZC_ZQ;
                        timer_reg <= zq_len(l_op_reg);
                        if (l_op_reg == lmzc_pkg::ZQ_INIT_CODE) begin
                            zq_kind <= lmzc_pkg::ZQ_KIND_INIT;
                        end else if (l_op_reg == lmzc_pkg::ZQ_LONG_CODE) begin
                            zq_kind <= lmzc_pkg::ZQ_KIND_LONG;
                        end else if (l_op_reg == lmzc_pkg::ZQ_SHORT_CODE) begin
                            zq_kind <= lmzc_pkg::ZQ_KIND_SHORT;
                        end else begin
                            zq_kind <= lmzc_pkg::ZQ_KIND_NONE;
                        end
                    end else if (wr_evt && !is_zq) begin
                        state_reg <= lmzc_pkg::LMZC_MRW;
                        timer_reg <= 20'(lmzc_pkg::MRW_CYC);
                    end
                end
                default: begin
                    if (timer_reg == 20'h0) begin
                        state_reg <= lmzc_pkg::LMZC_IDLE;
                        zq_kind   <= lmzc_pkg::ZQ_KIND_NONE;
                    end
                end
            endcase
        end
    end

    // ************************************************
    // Mode register storage
    // ************************************************
    generate
        for (genvar i = 0; i < NUM_MR; i++) begin : g_mr
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mr_reg[i] <= MR_DEF[i*8 +: 8];
                end else if (init_done) begin
                    mr_reg[i] <= MR_DEF[i*8 +: 8];
                end else if (wr_evt && banks_idle && !ro_hit && !is_reset
                             && !is_zq
                             && (state_reg == lmzc_pkg::LMZC_IDLE)
                             && (l_ma_reg[3:0] == 4'(i))) begin
                    mr_reg[i] <= l_op_reg;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mr_rd_data <= lmzc_pkg::MR_RESET_VAL;
        end else begin
            mr_rd_data <= mr_reg[mr_rd_idx];
        end
    end

    // ************************************************
    // Status flags
    // ************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mrw_busy    <= 1'b0;
            init_busy   <= 1'b0;
            zq_busy     <= 1'b0;
            zq_default  <= 1'b1;
            array_undef <= 1'b0;
        end else begin
            mrw_busy  <= (state_reg == lmzc_pkg::LMZC_MRW);
            init_busy <= (state_reg == lmzc_pkg::LMZC_INIT);
            zq_busy   <= (state_reg == lmzc_pkg::LMZC_ZQ);
            if (zq_sync_reg[1] || init_done) begin
                zq_default <= 1'b1;
            end else if ((state_reg == lmzc_pkg::LMZC_ZQ) &&
                         (timer_reg == 20'h0)) begin
                zq_default <= (zq_kind == lmzc_pkg::ZQ_KIND_NONE);
            end
            if (init_done) begin
                array_undef <= 1'b1;
            end else if (array_clr) begin
                array_undef <= 1'b0;
            end
        end
    end

    // ************************************************
    // Clock stop and ready tracking
    // ************************************************
    logic [7:0] quiet_cnt_reg;
    logic [7:0] rdy_cnt_reg;
    logic       stopped_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_cnt_reg <= 8'h00;
            stopped_reg   <= 1'b1;
            rdy_cnt_reg   <= 8'h00;
            dev_ready     <= 1'b0;
        end else begin
            if (hb_evt) begin
                quiet_cnt_reg <= 8'h00;
                stopped_reg   <= 1'b0;
            end else if (quiet_cnt_reg == 8'(lmzc_pkg::STOP_CYC)) begin
                stopped_reg <= 1'b1;
            end else begin
                quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
            end
            if (stopped_reg || !rdy_sync_reg[1]) begin
                rdy_cnt_reg <= 8'h00;
                dev_ready   <= 1'b0;
            end else if (rdy_cnt_reg == 8'(lmzc_pkg::RDY_CYC)) begin
                dev_ready <= 1'b1;
            end else begin
                rdy_cnt_reg <= rdy_cnt_reg + 8'h01;
            end
        end
    end
endmodule : lmzc_core

// ---- bench/lmzc_core_chk.sv ----
// Checker for the write, ZQ and clock change status ports
`timescale 1ns/1ps
module lmzc_core_chk #(
    parameter int INIT4_CYC  = lmzc_pkg::INIT4_CYC,
    parameter int ZQINIT_CYC = lmzc_pkg::ZQINIT_CYC,
    parameter int ZQCL_CYC   = lmzc_pkg::ZQCL_CYC
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Watched inputs
    input wire logic       cke,
    input wire logic       zq_tied_high,
    // Status outputs
    input wire logic       mrw_busy,
    input wire logic       init_busy,
    input wire logic       zq_busy,
    input wire logic [1:0] zq_kind,
    input wire logic       zq_default,
    input wire logic       array_undef,
    input wire logic       mrw_refused,
    input wire logic       dev_ready
);
    logic [1:0]  kind_q;
    logic [15:0] zq_cnt;
    logic [15:0] init_cnt;
    int          zq_exp;

    // ************************************************
    // Period counters and last calibration kind
    // ************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kind_q   <= lmzc_pkg::ZQ_KIND_NONE;
            zq_cnt   <= 16'h0;
            init_cnt <= 16'h0;
        end else begin
            kind_q   <= (zq_busy && zq_cnt == 16'h0) ? zq_kind : kind_q;
            zq_cnt   <= zq_busy ? zq_cnt + 16'h1 : 16'h0;
            init_cnt <= init_busy ? init_cnt + 16'h1 : 16'h0;
        end
    end

    always_comb begin
        case (kind_q)
            lmzc_pkg::ZQ_KIND_INIT:  zq_exp = ZQINIT_CYC;
            lmzc_pkg::ZQ_KIND_LONG:  zq_exp = ZQCL_CYC;
            lmzc_pkg::ZQ_KIND_SHORT: zq_exp = lmzc_pkg::ZQCS_CYC;
            default:                 zq_exp = lmzc_pkg::ZQRESET_CYC;
        endcase
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_busy_onehot: assert property (
        $onehot0({mrw_busy, init_busy, zq_busy}))
        else $error("more than one busy flag high");
    a_refuse_quiet: assert property (
        mrw_refused |-> !mrw_busy ##1 (!mrw_refused && !mrw_busy)[*3])
        else $error("refused write did not stay quiet");
    a_strap_ignore: assert property (
        zq_tied_high[*6] |-> !$rose(zq_busy))
        else $error("calibration started with strap high");
    a_zq_kind_hold: assert property (
        zq_busy && $past(zq_busy) && int'(zq_cnt) < zq_exp
            |-> $stable(zq_kind))
        else $error("calibration kind changed in period");
    a_zq_period_len: assert property (
        $fell(zq_busy) |-> int'(zq_cnt) >= zq_exp - 1
                           && int'(zq_cnt) <= zq_exp + 1)
        else $error("calibration period length wrong");
    a_zq_default_end: assert property (
        $fell(zq_busy) |-> ##[0:2]
            (zq_default == (kind_q == lmzc_pkg::ZQ_KIND_NONE)))
        else $error("impedance default flag wrong after period");
    a_init_len: assert property (
        $fell(init_busy) |-> int'(init_cnt) >= INIT4_CYC - 1
                             && int'(init_cnt) <= INIT4_CYC + 1)
        else $error("initialization period length wrong");
    a_init_undef: assert property (
        $fell(init_busy) |-> ##[0:2] array_undef)
        else $error("array not flagged undefined after reset");
    a_ready_cke: assert property (
        (!cke)[*5] |-> !dev_ready)
        else $error("ready held with clock enable low");
endmodule : lmzc_core_chk

bind lmzc_core lmzc_core_chk #(
    .INIT4_CYC(INIT4_CYC), .ZQINIT_CYC(ZQINIT_CYC), .ZQCL_CYC(ZQCL_CYC)
) u_chk (
    .clk(clk), .rst_n(rst_n), .cke(cke), .zq_tied_high(zq_tied_high),
    .mrw_busy(mrw_busy), .init_busy(init_busy), .zq_busy(zq_busy),
    .zq_kind(zq_kind), .zq_default(zq_default), .array_undef(array_undef),
    .mrw_refused(mrw_refused), .dev_ready(dev_ready)
);

// ---- bench/lmzc_ctrl_model.sv ----
// Behavioural model of the controller driving the link pins
`timescale 1ns/1ps
module lmzc_ctrl_model (
    // Link pins
    output logic                      ck_t,
    output logic                      cke,
    output logic                      cs_n,
    output logic [lmzc_pkg::CA_W-1:0] ca
);
    logic ck_en;

    // ************************************************
    // Link clock, held low while stopped
    // ************************************************
    initial begin
        ck_en = 1'b1;
        ck_t  = 1'b0;
        cke   = 1'b1;
        cs_n  = 1'b1;
        ca    = 10'h155;
        #3;
        forever begin
            #6;
            ck_t = ck_en ? ~ck_t : 1'b0;
        end
    end

    // Deselected command lines keep changing
    always #6 if (cs_n) ca = ~ca;

    // Two-edge write, then a no-operation launch edge
    task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
        @(negedge ck_t);
        #1;
        cs_n = 1'b0;
        ca   = {ma[5:0], 4'h0};
        @(posedge ck_t);
        #1;
        ca = {op, ma[7:6]};
        @(negedge ck_t);
        #1;
        cs_n = 1'b1;
    endtask : mrw

    task automatic cke_low();
        @(posedge ck_t);
        #1;
        cke = 1'b0;
        repeat (2) @(posedge ck_t);
        ck_en = 1'b0;
    endtask : cke_low

    task automatic cke_high();
        ck_en = 1'b1;
        repeat (2) @(posedge ck_t);
        #1;
        cke = 1'b1;
    endtask : cke_high
endmodule : lmzc_ctrl_model

// ---- bench/lmzc_core_bench.sv ----
// Self-checking bench for the write, ZQ and clock change block
`timescale 1ns/1ps
module lmzc_core_bench;
    logic                      clk, rst_n, ck_t, cke, cs_n;
    logic [lmzc_pkg::CA_W-1:0] ca;
    logic                      zq_tied_high, banks_idle, array_clr;
    logic [3:0]                mr_rd_idx;
    logic [7:0]                mr_rd_data, ma, op;
    logic                      mrw_busy, init_busy, zq_busy, zq_default;
    logic [1:0]                zq_kind;
    logic                      array_undef, mrw_refused, dev_ready;
    logic [3:0]                flags;
    logic [31:0]               seed;
    logic [7:0]                exp_mr [16];
    int                        num_errors, samples_checked, seen;

    assign flags = {dev_ready, init_busy, zq_busy, mrw_busy};

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    lmzc_core #(.INIT4_CYC(20), .ZQINIT_CYC(30), .ZQCL_CYC(10)) dut (
        .clk(clk), .rst_n(rst_n), .ck_t(ck_t), .cke(cke), .cs_n(cs_n),
        .ca(ca), .zq_tied_high(zq_tied_high), .banks_idle(banks_idle),
        .array_clr(array_clr), .mr_rd_idx(mr_rd_idx),
        .mr_rd_data(mr_rd_data), .mrw_busy(mrw_busy), .init_busy(init_busy),
        .zq_busy(zq_busy), .zq_kind(zq_kind), .zq_default(zq_default),
        .array_undef(array_undef), .mrw_refused(mrw_refused),
        .dev_ready(dev_ready));

    lmzc_ctrl_model u_ctrl (.ck_t(ck_t), .cke(cke), .cs_n(cs_n), .ca(ca));

    // Overall run limit
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    // ************************************************
    // Expectations, checks and drivers
    // ************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic stores(input logic [7:0] a);
        return a < 8'h10 && a > 8'h01 && a != lmzc_pkg::ZQ_MA_DEF;
    endfunction : stores

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic step();
        @(posedge clk);
        #2;
    endtask : step

    task automatic wait_flag(input int sel, input logic val, input int lim);
        int n;
        n = 0;
        do begin
            step();
            n++;
        end while (flags[sel] !== val && n < lim);
        check(8'(flags[sel]), 8'(val));
        if (flags[sel] !== val)
            finish_test();
    endtask : wait_flag

    task automatic do_mrw(input logic [7:0] a, input logic [7:0] d, int sel);
        u_ctrl.mrw(a, d);
        wait_flag(sel, 1'b1, 12);
        wait_flag(sel, 1'b0, 100);
        repeat (6) step();
    endtask : do_mrw

    task automatic rd(input logic [3:0] idx);
        mr_rd_idx = idx;
        repeat (2) step();
        check(mr_rd_data, exp_mr[idx]);
    endtask : rd

    initial begin
        {rst_n, zq_tied_high, array_clr, mr_rd_idx} = '0;
        banks_idle = 1'b1;
        {num_errors, samples_checked} = '0;
        seed = 32'h1b46;
        foreach (exp_mr[i]) exp_mr[i] = lmzc_pkg::MR_RESET_VAL;
        repeat (3) @(posedge clk);
        #2 rst_n = 1'b1;
        wait_flag(3, 1'b1, 200);
        for (int k = 0; k < 9; k++) begin
            seed = lfsr(seed);
            ma = (k == 0) ? 8'h85 : {4'h0, seed[3:0]};
            ma = (ma == lmzc_pkg::ZQ_MA_DEF) ? 8'h01 : ma;
            op = seed[15:8];
            do_mrw(ma, op, 0);
            if (stores(ma)) exp_mr[ma[3:0]] = op;
            rd(ma[3:0]);
        end
        banks_idle = 1'b0;
        u_ctrl.mrw(8'h02, 8'ha5);
        seen = 0;
        repeat (12) begin
            step();
            if (mrw_refused === 1'b1) seen++;
        end
        check(8'(seen), 8'h01);
        banks_idle = 1'b1;
        rd(4'h2);
        for (int c = 1; c <= 4; c++) begin
            op = 8'(c);
            u_ctrl.mrw(lmzc_pkg::ZQ_MA_DEF, op);
            wait_flag(1, 1'b1, 12);
            check(8'(zq_kind), (c == 4) ? 8'h00 : op);
            wait_flag(1, 1'b0, 100);
            repeat (6) step();
            check(8'(zq_default), 8'(c == 4));
        end
        rd(4'ha);
        zq_tied_high = 1'b1;
        repeat (4) step();
        u_ctrl.mrw(lmzc_pkg::ZQ_MA_DEF, lmzc_pkg::ZQ_LONG_CODE);
        seen = 0;
        repeat (30) begin
            step();
            if (zq_busy !== 1'b0) seen++;
        end
        check(8'(seen), 8'h00);
        zq_tied_high = 1'b0;
        array_clr = 1'b1;
        step();
        array_clr = 1'b0;
        step();
        check(8'(array_undef), 8'h00);
        do_mrw(lmzc_pkg::RESET_MA_DEF, 8'h00, 2);
        check(8'(array_undef), 8'h01);
        foreach (exp_mr[i]) exp_mr[i] = lmzc_pkg::MR_RESET_VAL;
        for (int i = 0; i < 16; i++) rd(4'(i));
        u_ctrl.cke_low();
        repeat (8) step();
        check(8'(dev_ready), 8'h00);
        u_ctrl.cke_high();
        wait_flag(3, 1'b1, 40);
        do_mrw(8'h07, seed[23:16], 0);
        exp_mr[7] = seed[23:16];
        rd(4'h7);
        finish_test();
    end
endmodule : lmzc_core_bench
